// >>> inc/lcdcd_pkg.sv
// Constants and types for the LCD RAM command decoder
`default_nettype none
package lcdcd_pkg;
    localparam int COL_W = 8;
    localparam int PAGE_W = 4;
    localparam int RAM_AW = 11;
    localparam logic [10:0] NUM_COLS = 11'h084;
    localparam logic [7:0] LAST_COL = 8'h83;
    localparam logic [3:0] IND_PAGE = 4'h8;
    localparam int RAM_WORDS = 1188;
    // Reset values
    localparam logic [7:0] RST_COL = 8'h00;
    localparam logic [3:0] RST_PAGE = 4'h0;
    localparam logic [5:0] RST_LINE = 6'h00;
    localparam logic RST_SCAN = 1'b0;
    localparam logic RST_BIAS = 1'b0;
    localparam logic [4:0] CONTRAST_OFF = 5'h00;
    // Full command bytes
    localparam logic [7:0] CMD_RMW = 8'hE0;
    localparam logic [7:0] CMD_END = 8'hEE;
    localparam logic [7:0] CMD_SRST = 8'hE2;
    // Opcodes on the upper seven bits, D0 carries the setting
    localparam logic [6:0] OP_DISP = 7'h57;
    localparam logic [6:0] OP_ADC = 7'h50;
    localparam logic [6:0] OP_REV = 7'h53;
    localparam logic [6:0] OP_ALL = 7'h52;
    localparam logic [6:0] OP_BIAS = 7'h51;
    localparam logic [6:0] OP_IND = 7'h56;
    // Opcodes on shorter prefixes
    localparam logic [3:0] OP_PAGE = 4'hB;
    localparam logic [3:0] OP_COLH = 4'h1;
    localparam logic [3:0] OP_COLL = 4'h0;
    localparam logic [3:0] OP_SCAN = 4'hC;
    localparam logic [1:0] OP_LINE = 2'h1;
    localparam logic [4:0] OP_PWR = 5'h05;
    localparam logic [2:0] OP_CONTRAST = 3'h4;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLINK_W = 25;
    // Synchronised pin vector layout
    localparam int PIN_W = 15;
    localparam int PIN_WR = 14;
    localparam int PIN_RD = 13;
    localparam int PIN_CDS = 12;
    localparam int PIN_SER = 11;
    localparam int PIN_SCLK = 10;
    localparam int PIN_SDAT = 9;
    localparam int PIN_SCS = 8;
    localparam logic [14:0] PIN_IDLE = 15'h6100;

    typedef struct packed {
        logic displayOn;
        logic segReverse;
        logic displayInvert;
        logic entireOn;
        logic powerSave;
        logic comScanReverse;
        logic biasSelect;
        logic biasApplied;
    } lcdcd_disp_t;

    typedef struct packed {
        logic [2:0] powerCtrl;
        logic [4:0] contrast;
        logic contrastEnable;
    } lcdcd_pwr_t;

    typedef struct packed {
        logic [7:0] col;
        logic [7:0] colSaved;
        logic [3:0] page;
        logic [5:0] startLine;
        logic rmw;
        logic [7:0] readLatch;
        logic [7:0] dataOut;
        logic dataOe;
        lcdcd_disp_t disp;
        lcdcd_pwr_t pwr;
        logic indicatorOn;
        logic blinkPhase;
        logic [BLINK_W-1:0] blinkCnt;
        logic indA;
        logic indB;
        logic wrLowPrev;
        logic rdLowPrev;
        logic sclkPrev;
        logic [7:0] shReg;
        logic [2:0] shCnt;
    } lcdcd_state_t;
endpackage : lcdcd_pkg
`default_nettype wire

// >>> hdl/lcdcd_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module lcdcd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : lcdcd_sync
`default_nettype wire

// >>> hdl/lcdcd_core.sv
// Command decoder, display RAM and control state of the LCD controller
// Notes on behaviour
// R1 - Data write stores byte, column advances
// R2 - Data read returns byte, column advances
// R3 - First read after column set is dummy
// R4 - Serial link writes only, never reads
// R5 - 0xA0/A1 sets segment direction
// R6 - 0xA6/A7 selects normal or reverse polarity
// R7 - 0xA4/A5 forces all pixels, overrides polarity
// R8 - Entire-on while display off enters power save
// R9 - 0xA2/A3 bias, applied only with follower
// R10 - 0xE0 saves column; reads do not advance
// R11 - 0xEE ends mode, restores saved column
// R12 - Host always closes session with end
// R13 - Host sets no column during session
// R14 - 0xE2 resets line, column, page, scan
// R15 - Soft reset leaves power control alone
// R16 - 0xC? sets common scan from D3
// R17 - 00101 prefix loads 3-bit power control
// R18 - 100 prefix loads 5-bit contrast
// R19 - 0xAC/AD sets indicator, nothing else does
// R20 - Indicator blinks with about one second period
// R21 - 0xAE/AF switches display off or on
// R22 - Column loaded as two nibble commands
// R23 - 1011 prefix sets page; page 8 D0 only
// R24 - Unknown command bytes change nothing
// R25 - Column stops at 131, no wrap
`timescale 1ns/1ns
`default_nettype none
module lcdcd_core #(
    parameter int unsigned BLINK_HALF = lcdcd_pkg::BLINK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrN,
    input wire logic rdN,
    input wire logic cmdDataSelect,
    input wire logic [7:0] dataIn,
    input wire logic serialSel,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serCsN,
    output logic [7:0] dataOut,
    output logic dataOe,
    output var lcdcd_pkg::lcdcd_disp_t dispCtrl,
    output var lcdcd_pkg::lcdcd_pwr_t pwrCtrl,
    output logic [5:0] startLine,
    output logic [7:0] columnAddr,
    output logic [3:0] pageAddr,
    output logic rmwActive,
    output logic indicatorOn,
    output logic indicatorDriveA,
    output logic indicatorDriveB
);
    logic [1:0] rstSync_r;
    logic rstN;
    logic [lcdcd_pkg::PIN_W-1:0] pinRaw;
    logic [lcdcd_pkg::PIN_W-1:0] pinQ;
    lcdcd_pkg::lcdcd_state_t st_r;
    lcdcd_pkg::lcdcd_state_t st_nxt;
    logic [7:0] ram [0:lcdcd_pkg::RAM_WORDS-1];
    logic wrLow, rdLow, cds, serOn, sclk, sdat, scsN;
    logic [7:0] din;
    logic parWrEv, serBitEv, serWrEv, wrEv, rdEv, cmdEv;
    logic [7:0] wrByte;
    logic addrOk, ramWe;
    logic [lcdcd_pkg::RAM_AW-1:0] ramIdx;
    logic [7:0] ramRd, ramWd;
    logic [7:0] status;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    assign pinRaw = {wrN, rdN, cmdDataSelect, serialSel, serClk, serData, serCsN, dataIn};

    lcdcd_sync #(.W(lcdcd_pkg::PIN_W), .INIT(lcdcd_pkg::PIN_IDLE)) uPinSync (
        .clk(clk),
        .rstN(rstN),
        .d(pinRaw),
        .q(pinQ)
    );

    assign wrLow = !pinQ[lcdcd_pkg::PIN_WR];
    assign rdLow = !pinQ[lcdcd_pkg::PIN_RD];
    assign cds = pinQ[lcdcd_pkg::PIN_CDS];
    assign serOn = pinQ[lcdcd_pkg::PIN_SER];
    assign sclk = pinQ[lcdcd_pkg::PIN_SCLK];
    assign sdat = pinQ[lcdcd_pkg::PIN_SDAT];
    assign scsN = pinQ[lcdcd_pkg::PIN_SCS];
    assign din = pinQ[7:0];

    // Bus events: parallel write ends on the strobe's rising edge
    assign parWrEv = st_r.wrLowPrev && !wrLow && !serOn;
    assign serBitEv = serOn && !scsN && sclk && !st_r.sclkPrev;
    assign serWrEv = serBitEv && (st_r.shCnt == 3'h7);
    assign wrEv = parWrEv || serWrEv;
    assign wrByte = serWrEv ? {st_r.shReg[6:0], sdat} : din;
    assign rdEv = !st_r.rdLowPrev && rdLow && !serOn; // see R4
    assign cmdEv = wrEv && !cds;

    // Display RAM addressing
    assign addrOk = (st_r.page <= lcdcd_pkg::IND_PAGE) && (st_r.col <= lcdcd_pkg::LAST_COL);
    assign ramIdx = lcdcd_pkg::RAM_AW'({7'h00, st_r.page} * lcdcd_pkg::NUM_COLS)
        + {3'h0, st_r.col};
    assign ramRd = addrOk ? ram[ramIdx] : 8'h00;
    assign ramWe = wrEv && cds && addrOk;
    // Indicator page keeps only bit 0
    assign ramWd = (st_r.page == lcdcd_pkg::IND_PAGE) ? {7'h00, wrByte[0]} : wrByte; // see R23
    assign status = {1'b0, !st_r.disp.segReverse, !st_r.disp.displayOn, 5'h00};

    always_ff @(posedge clk)
    begin
        if (ramWe)
            ram[ramIdx] <= ramWd; // see R1
    end

    function automatic logic [7:0] colInc(input logic [7:0] c);
        colInc = (c < lcdcd_pkg::LAST_COL) ? c + 8'h01 : c; // see R25
    endfunction : colInc

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.wrLowPrev = wrLow;
        st_nxt.rdLowPrev = rdLow;
        st_nxt.sclkPrev = sclk;
        st_nxt.dataOe = rdLow && !serOn; // see R4
        // Serial shift, MSB first
        if (!serOn || scsN)
            st_nxt.shCnt = 3'h0;
        else if (serBitEv)
        begin
            st_nxt.shReg = {st_r.shReg[6:0], sdat};
            st_nxt.shCnt = st_r.shCnt + 3'h1;
        end
        if (wrEv && cds)
            st_nxt.col = colInc(st_r.col); // see R1 R10
        else if (wrEv)
        begin
            if (wrByte[7:1] == lcdcd_pkg::OP_DISP)
            begin
                st_nxt.disp.displayOn = wrByte[0]; // see R21
                if (wrByte[0])
                    st_nxt.disp.powerSave = 1'b0;
            end
            else if (wrByte[7:6] == lcdcd_pkg::OP_LINE)
                st_nxt.startLine = wrByte[5:0];
            else if (wrByte[7:4] == lcdcd_pkg::OP_PAGE)
                st_nxt.page = wrByte[3:0]; // see R23
            else if (wrByte[7:4] == lcdcd_pkg::OP_COLH)
                st_nxt.col = {wrByte[3:0], st_r.col[3:0]}; // see R22
            else if (wrByte[7:4] == lcdcd_pkg::OP_COLL)
                st_nxt.col = {st_r.col[7:4], wrByte[3:0]}; // see R22
            else if (wrByte[7:1] == lcdcd_pkg::OP_ADC)
                st_nxt.disp.segReverse = wrByte[0]; // see R5
            else if (wrByte[7:1] == lcdcd_pkg::OP_REV)
                st_nxt.disp.displayInvert = wrByte[0]; // see R6
            else if (wrByte[7:1] == lcdcd_pkg::OP_ALL)
            begin
                st_nxt.disp.entireOn = wrByte[0]; // see R7
                st_nxt.disp.powerSave = wrByte[0] && !st_r.disp.displayOn; // see R8
            end
            else if (wrByte[7:1] == lcdcd_pkg::OP_BIAS)
                st_nxt.disp.biasSelect = wrByte[0]; // see R9
            else if (wrByte[7:1] == lcdcd_pkg::OP_IND)
                st_nxt.indicatorOn = wrByte[0]; // see R19
            else if (wrByte == lcdcd_pkg::CMD_RMW)
            begin
                st_nxt.rmw = 1'b1; // see R10
                st_nxt.colSaved = st_r.col;
            end
            else if (wrByte == lcdcd_pkg::CMD_END)
            begin
                if (st_r.rmw)
                    st_nxt.col = st_r.colSaved; // see R11
                st_nxt.rmw = 1'b0;
            end
            else if (wrByte == lcdcd_pkg::CMD_SRST)
            begin
                // Power control untouched, see R14 R15
                st_nxt.startLine = lcdcd_pkg::RST_LINE;
                st_nxt.col = lcdcd_pkg::RST_COL;
                st_nxt.page = lcdcd_pkg::RST_PAGE;
                st_nxt.disp.comScanReverse = lcdcd_pkg::RST_SCAN;
            end
            else if (wrByte[7:4] == lcdcd_pkg::OP_SCAN)
                st_nxt.disp.comScanReverse = wrByte[3]; // see R16
            else if (wrByte[7:3] == lcdcd_pkg::OP_PWR)
                st_nxt.pwr.powerCtrl = wrByte[2:0]; // see R17
            else if (wrByte[7:5] == lcdcd_pkg::OP_CONTRAST)
                st_nxt.pwr.contrast = wrByte[4:0]; // see R18
            // Other bytes fall through, see R24
        end
        if (rdEv)
        begin
            if (cds)
            begin
                // Pipelined latch gives the dummy read, see R2 R3
                st_nxt.dataOut = st_r.readLatch;
                st_nxt.readLatch = ramRd;
                if (!st_r.rmw)
                    st_nxt.col = colInc(st_r.col); // see R10
            end
            else
                st_nxt.dataOut = status;
        end
        st_nxt.disp.biasApplied = st_r.pwr.powerCtrl[0] ? st_r.disp.biasSelect
            : lcdcd_pkg::RST_BIAS; // see R9
        st_nxt.pwr.contrastEnable = (st_r.pwr.contrast != lcdcd_pkg::CONTRAST_OFF); // see R18
        // Indicator blink timer, see R20
        if (!st_r.indicatorOn)
        begin
            st_nxt.blinkCnt = '0;
            st_nxt.blinkPhase = 1'b0;
        end
        else if (st_r.blinkCnt == lcdcd_pkg::BLINK_W'(BLINK_HALF - 1))
        begin
            st_nxt.blinkCnt = '0;
            st_nxt.blinkPhase = !st_r.blinkPhase;
        end
        else
            st_nxt.blinkCnt = st_r.blinkCnt + lcdcd_pkg::BLINK_W'(1);
        st_nxt.indA = st_r.indicatorOn && st_r.blinkPhase;
        st_nxt.indB = 1'b0;
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign dataOut = st_r.dataOut;
    assign dataOe = st_r.dataOe;
    assign dispCtrl = st_r.disp;
    assign pwrCtrl = st_r.pwr;
    assign startLine = st_r.startLine;
    assign columnAddr = st_r.col;
    assign pageAddr = st_r.page;
    assign rmwActive = st_r.rmw;
    assign indicatorOn = st_r.indicatorOn;
    assign indicatorDriveA = st_r.indA;
    assign indicatorDriveB = st_r.indB;

    default clocking cbDef @(posedge clk);
    endclocking
    default disable iff (!rstN);

    property p_wr_adv;
        wrEv && cds && (st_r.col < lcdcd_pkg::LAST_COL) && !rdEv |=> st_r.col == $past(st_r.col) + 8'h01;
    endproperty
    a_wr_adv: assert property (p_wr_adv) else $error("column not advanced on write"); // see R1

    property p_rd_data;
        rdEv && cds |=> st_r.dataOut == $past(st_r.readLatch);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not from latch"); // see R2 R3

    property p_ser_no_oe;
        serOn |=> !dataOe;
    endproperty
    a_ser_no_oe: assert property (p_ser_no_oe) else $error("bus driven in serial mode"); // see R4

    property p_adc;
        cmdEv && wrByte[7:1] == lcdcd_pkg::OP_ADC |=> dispCtrl.segReverse == $past(wrByte[0]);
    endproperty
    a_adc: assert property (p_adc) else $error("segment direction not set"); // see R5

    property p_all_psave;
        cmdEv && wrByte == 8'hA5 && !dispCtrl.displayOn |=> dispCtrl.powerSave && dispCtrl.entireOn;
    endproperty
    a_all_psave: assert property (p_all_psave) else $error("power save not entered"); // see R7 R8

    property p_bias;
        !pwrCtrl.powerCtrl[0] |=> dispCtrl.biasApplied == lcdcd_pkg::RST_BIAS;
    endproperty
    a_bias: assert property (p_bias) else $error("bias applied with follower off"); // see R9

    property p_rmw_hold;
        rmwActive && rdEv && !wrEv |=> $stable(st_r.col);
    endproperty
    a_rmw_hold: assert property (p_rmw_hold) else $error("read advanced column in session"); // see R10

    property p_end;
        cmdEv && rmwActive && wrByte == lcdcd_pkg::CMD_END && !rdEv |=> st_r.col == $past(st_r.colSaved) && !rmwActive;
    endproperty
    a_end: assert property (p_end) else $error("column not restored on end"); // see R11

    property p_srst;
        cmdEv && wrByte == lcdcd_pkg::CMD_SRST && !rdEv |=> st_r.col == 8'h00 && pageAddr == 4'h0 && $stable(pwrCtrl.powerCtrl);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset wrong"); // see R14 R15

    property p_pwr;
        cmdEv && wrByte[7:3] == lcdcd_pkg::OP_PWR |=> pwrCtrl.powerCtrl == $past(wrByte[2:0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power control not loaded"); // see R17

    property p_sat;
        st_r.col == lcdcd_pkg::LAST_COL && !cmdEv |=> st_r.col == lcdcd_pkg::LAST_COL;
    endproperty
    a_sat: assert property (p_sat) else $error("column wrapped past last"); // see R25

    property p_ind_off;
        !indicatorOn |=> !indicatorDriveA;
    endproperty
    a_ind_off: assert property (p_ind_off) else $error("indicator drive while off"); // see R20
endmodule : lcdcd_core
`default_nettype wire

// >>> dv/lcdcd_host_model.sv
// Host processor model driving the parallel and serial pins
`timescale 1ns/1ns
`default_nettype none
module lcdcd_host_model (
    input wire logic clk,
    output logic wrN,
    output logic rdN,
    output logic cmdDataSelect,
    output logic [7:0] dataIn,
    output logic serialSel,
    output logic serClk,
    output logic serData,
    output logic serCsN,
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    initial
    begin
        wrN = 1'b1;
        rdN = 1'b1;
        cmdDataSelect = 1'b0;
        dataIn = 8'h00;
        serialSel = 1'b0;
        serClk = 1'b1;
        serData = 1'b0;
        serCsN = 1'b1;
    end

    // One byte, parallel or serial; serial clock idles high between frames
    task automatic write_byte(input logic cds, input logic [7:0] b, input logic ser);
        @(posedge clk);
        cmdDataSelect <= cds;
        if (ser)
        begin
            serialSel <= 1'b1;
            serCsN <= 1'b0;
            for (int i = 7; i >= 0; i--)
            begin
                serClk <= 1'b0;
                serData <= b[i];
                repeat (3) @(posedge clk);
                serClk <= 1'b1;
                repeat (3) @(posedge clk);
            end
            serCsN <= 1'b1;
            serData <= ~b[0];
        end
        else
        begin
            dataIn <= b;
            wrN <= 1'b0;
            repeat (3) @(posedge clk);
            wrN <= 1'b1;
            repeat (3) @(posedge clk);
            dataIn <= ~b;
        end
        cmdDataSelect <= ~cds;
        repeat (3) @(posedge clk);
        serialSel <= 1'b0;
    endtask : write_byte

    // Read strobe held until the answer has settled
    task automatic read_byte(input logic cds, input logic ser, output logic [7:0] d,
                             output logic oe);
        @(posedge clk);
        cmdDataSelect <= cds;
        serialSel <= ser;
        rdN <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        d = dataOut;
        oe = dataOe;
        @(posedge clk);
        rdN <= 1'b1;
        repeat (5) @(posedge clk);
        cmdDataSelect <= ~cds;
        serialSel <= 1'b0;
    endtask : read_byte
endmodule : lcdcd_host_model
`default_nettype wire

// >>> dv/lcd_ram_command_decoder_tb_top.sv
// Self-checking testbench for the LCD RAM command decoder
`timescale 1ns/1ns
`default_nettype none
module lcd_ram_command_decoder_tb_top;
    localparam int unsigned BLINK = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wrN, rdN, cmdDataSelect, serialSel, serClk, serData, serCsN, dataOe;
    logic rmwActive, indicatorOn, indicatorDriveA, indicatorDriveB, expRmw, expInd, rdOe;
    logic [7:0] dataIn, dataOut, columnAddr, expCol, expSaved, rdVal;
    logic [5:0] startLine, expLine;
    logic [3:0] pageAddr, expPage;
    lcdcd_pkg::lcdcd_disp_t dispCtrl, expD;
    lcdcd_pkg::lcdcd_pwr_t pwrCtrl, expP;
    logic [7:0] ctl [$] = '{8'hA1, 8'hA7, 8'hA5, 8'hAF, 8'hA4, 8'hA6, 8'hA0, 8'hA3, 8'h2F,
        8'hA2, 8'h2A, 8'hA3, 8'hCF, 8'hC7, 8'h9F, 8'h80, 8'h81, 8'h65, 8'hAD, 8'hA8,
        8'hEE, 8'hAE, 8'hA5, 8'hA7, 8'hA1, 8'hAC, 8'hAD};
    logic [7:0] dat [$] = '{8'h3C, 8'hA5, 8'h5A};
    logic [7:0] srst [$] = '{8'h65, 8'hC8, 8'h2F, 8'h95, 8'hB3, 8'hE2};
    int n_mismatch = 0;
    int compares = 0;

    always #(lcdcd_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

    lcdcd_core #(.BLINK_HALF(BLINK)) dut (.clk(clk), .rst_n(rst_n), .wrN(wrN), .rdN(rdN),
        .cmdDataSelect(cmdDataSelect), .dataIn(dataIn), .serialSel(serialSel),
        .serClk(serClk), .serData(serData), .serCsN(serCsN), .dataOut(dataOut),
        .dataOe(dataOe), .dispCtrl(dispCtrl), .pwrCtrl(pwrCtrl), .startLine(startLine),
        .columnAddr(columnAddr), .pageAddr(pageAddr), .rmwActive(rmwActive),
        .indicatorOn(indicatorOn), .indicatorDriveA(indicatorDriveA),
        .indicatorDriveB(indicatorDriveB));

    lcdcd_host_model host (.clk(clk), .wrN(wrN), .rdN(rdN), .cmdDataSelect(cmdDataSelect),
        .dataIn(dataIn), .serialSel(serialSel), .serClk(serClk), .serData(serData),
        .serCsN(serCsN), .dataOut(dataOut), .dataOe(dataOe));

    task automatic report_and_stop;
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_state;
        chk({24'h000000, dispCtrl}, {24'h000000, expD}, "display control");
        chk({23'h000000, pwrCtrl}, {23'h000000, expP}, "power control");
        chk({24'h000000, columnAddr}, {24'h000000, expCol}, "column");
        chk({19'h00000, startLine, pageAddr, rmwActive, indicatorOn, indicatorDriveB},
            {19'h00000, expLine, expPage, expRmw, expInd, 1'b0}, "line page mode indicator");
    endtask : chk_state

    task automatic init_exp;
        expD = '0;
        expP = '0;
        {expCol, expSaved, expLine, expPage, expRmw, expInd} = '0;
    endtask : init_exp

    // Command byte with the expected effect on the control state
    task automatic cmd(input logic [7:0] b, input logic ser);
        host.write_byte(1'b0, b, ser);
        if (b[7:1] == 7'h57)
            {expD.displayOn, expD.powerSave} = {b[0], expD.powerSave & ~b[0]};
        else if (b[7:1] == 7'h50)
            expD.segReverse = b[0];
        else if (b[7:1] == 7'h53)
            expD.displayInvert = b[0];
        else if (b[7:1] == 7'h52)
            {expD.entireOn, expD.powerSave} = {b[0], b[0] & ~expD.displayOn};
        else if (b[7:1] == 7'h51)
            expD.biasSelect = b[0];
        else if (b[7:1] == 7'h56)
            expInd = b[0];
        else if (b == 8'hE2)
            {expLine, expCol, expPage, expD.comScanReverse} = 19'h00000;
        else if (b == 8'hE0)
            {expSaved, expRmw} = {expCol, 1'b1};
        else if (b == 8'hEE && expRmw)
            {expCol, expRmw} = {expSaved, 1'b0};
        else if (b[7:3] == 5'h05)
            expP.powerCtrl = b[2:0];
        else if (b[7:5] == 3'h4)
            expP.contrast = b[4:0];
        else if (b[7:4] == 4'hC)
            expD.comScanReverse = b[3];
        else if (b[7:4] == 4'hB)
            expPage = b[3:0];
        else if (b[7:4] == 4'h1)
            expCol[7:4] = b[3:0];
        else if (b[7:4] == 4'h0)
            expCol[3:0] = b[3:0];
        else if (b[7:6] == 2'h1)
            expLine = b[5:0];
        expD.biasApplied = expD.biasSelect & expP.powerCtrl[0];
        expP.contrastEnable = |expP.contrast;
        chk_state();
    endtask : cmd

    task automatic setcol(input logic [7:0] c);
        cmd({4'h1, c[7:4]}, 1'b0);
        cmd({4'h0, c[3:0]}, 1'b0);
    endtask : setcol

    task automatic wdata(input logic [7:0] b, input logic ser);
        host.write_byte(1'b1, b, ser);
        if (expCol < 8'h83)
            expCol = expCol + 8'h01;
        chk_state();
    endtask : wdata

    task automatic rdata(input logic [7:0] exp, input logic dummy);
        host.read_byte(1'b1, 1'b0, rdVal, rdOe);
        if (!expRmw && expCol < 8'h83)
            expCol = expCol + 8'h01;
        chk({31'h00000000, rdOe}, 32'h00000001, "read enable");
        if (!dummy)
            chk({24'h000000, rdVal}, {24'h000000, exp}, "read data");
        chk_state();
    endtask : rdata

    // Two toggles of the indicator drive, counting the second half period
    task automatic chk_blink(input logic on);
        int n;
        logic prev;
        repeat (2)
        begin
            n = 0;
            prev = indicatorDriveA;
            while (indicatorDriveA === prev && n < 3 * BLINK)
            begin
                @(negedge clk);
                n++;
            end
        end
        chk(n, on ? BLINK : 3 * BLINK, "blink half period");
    endtask : chk_blink

    initial
    begin
        init_exp();
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk_state();
        host.read_byte(1'b0, 1'b0, rdVal, rdOe);
        chk({24'h000000, rdVal}, 32'h00000060, "status after reset");
        $display("test reset values finished");
        foreach (ctl[i])
            cmd(ctl[i], 1'b0);
        chk_blink(1'b1);
        cmd(8'hAC, 1'b0);
        chk_blink(1'b0);
        $display("test control commands finished");
        cmd(8'hB2, 1'b0);
        setcol(8'h05);
        foreach (dat[i])
            wdata(dat[i], 1'b0);
        setcol(8'h05);
        rdata(8'h00, 1'b1);
        foreach (dat[i])
            rdata(dat[i], 1'b0);
        $display("test data access finished");
        setcol(8'h06);
        cmd(8'hE0, 1'b0);
        rdata(8'h00, 1'b1);
        rdata(8'hA5, 1'b0);
        wdata(8'h77, 1'b0);
        cmd(8'hEE, 1'b0);
        rdata(8'h00, 1'b1);
        rdata(8'h77, 1'b0);
        $display("test read-modify-write finished");
        setcol(8'h83);
        wdata(8'hC3, 1'b0);
        wdata(8'h3E, 1'b0);
        setcol(8'h83);
        rdata(8'h00, 1'b1);
        rdata(8'h3E, 1'b0);
        cmd(8'hB8, 1'b0);
        setcol(8'h00);
        wdata(8'hFF, 1'b0);
        setcol(8'h00);
        rdata(8'h00, 1'b1);
        rdata(8'h01, 1'b0);
        $display("test column end and indicator page finished");
        cmd(8'hB3, 1'b1);
        setcol(8'h20);
        wdata(8'h96, 1'b1);
        host.read_byte(1'b1, 1'b1, rdVal, rdOe);
        chk({31'h00000000, rdOe}, 32'h00000000, "serial read enable");
        setcol(8'h20);
        rdata(8'h00, 1'b1);
        rdata(8'h96, 1'b0);
        $display("test serial link finished");
        foreach (srst[i])
            cmd(srst[i], 1'b0);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        init_exp();
        chk_state();
        $display("test resets finished");
        report_and_stop();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : lcd_ram_command_decoder_tb_top
`default_nettype wire
